// ===== src/flash_security_params.svh
// offsets, field positions, codes and reset values of the flash security decoder
`ifndef FLASH_SECURITY_PARAMS_SVH
`define FLASH_SECURITY_PARAMS_SVH
`define FSEC_ADDR_W 4
`define FSEC_OFS_STATUS 4'h2
`define FSEC_OFS_CTRL 4'h4
`define FSEC_BACKDOOR_HI 7
`define FSEC_BACKDOOR_LO 6
`define FSEC_ERASE_HI 5
`define FSEC_ERASE_LO 4
`define FSEC_FACTORY_HI 3
`define FSEC_FACTORY_LO 2
`define FSEC_STATE_HI 1
`define FSEC_STATE_LO 0
`define FSEC_CODE_10 2'h2
`define FSEC_CODE_00 2'h0
`define FSEC_CODE_11 2'h3
`define FSEC_RESET_STATUS 8'hff
`define FSEC_NVM_MODE_BIT 0
`endif

// ===== src/flash_security_pkg.sv
// types shared by the flash security decoder
package flash_security_pkg;
	typedef enum logic [1:0] {
		LOAD_WAIT,
		LOAD_DONE
	} load_state_t;
endpackage

// ===== src/flash_security_state_decoder.sv
// flash security status register and its access-permission decoder
`timescale 1ns/1ps
`default_nettype none
`include "flash_security_params.svh"

module flash_security_state_decoder (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [7:0] nvm_security_byte_in,
	input wire logic nvm_load_valid_in,
	input wire logic backdoor_unlock_in,
	input wire logic [`FSEC_ADDR_W-1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic write_in,
	input wire logic read_in,
	output logic [7:0] rdata_out,
	output logic load_done_out,
	output logic backdoor_allowed_out,
	output logic bulk_erase_allowed_out,
	output logic factory_access_out,
	output logic program_flash_blocked_out,
	output logic secure_out
);

	flash_security_pkg::load_state_t load_state;
	logic [7:0] flash_protection_status;
	logic nvm_normal_mode;
	logic [7:0] next_status;
	logic dec_secure;

	// secure unless the state field is exactly 10
	function automatic logic is_secure(input logic [7:0] r);
		is_secure = (r[`FSEC_STATE_HI:`FSEC_STATE_LO] != `FSEC_CODE_10);
	endfunction

	// factory analysis access granted for codes 00 and 11
	function automatic logic factory_granted(input logic [7:0] r);
		factory_granted = (r[`FSEC_FACTORY_HI:`FSEC_FACTORY_LO] == `FSEC_CODE_00)
			|| (r[`FSEC_FACTORY_HI:`FSEC_FACTORY_LO] == `FSEC_CODE_11);
	endfunction

	// next register contents: load, then backdoor force
	always_comb begin
		next_status = flash_protection_status;
		if (load_state == flash_security_pkg::LOAD_WAIT && nvm_load_valid_in) begin
			next_status = nvm_security_byte_in;
		end
		if (backdoor_unlock_in && (load_state == flash_security_pkg::LOAD_DONE)) begin
			next_status[`FSEC_STATE_HI:`FSEC_STATE_LO] = `FSEC_CODE_10;
		end
	end

	// status register: only hardware updates it, bus writes never reach it
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			flash_protection_status <= `FSEC_RESET_STATUS;
		end else begin
			flash_protection_status <= next_status;
		end
	end

	// reset-sequence load tracker
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			load_state <= flash_security_pkg::LOAD_WAIT;
		end else begin
			unique case (load_state)
				flash_security_pkg::LOAD_WAIT: begin
					if (nvm_load_valid_in) begin
						load_state <= flash_security_pkg::LOAD_DONE;
					end
				end
				flash_security_pkg::LOAD_DONE: begin
					load_state <= flash_security_pkg::LOAD_DONE;
				end
				default: begin
					load_state <= flash_security_pkg::LOAD_WAIT;
				end
			endcase
		end
	end

	// control register: nvm normal mode flag steers the bulk erase decision
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			nvm_normal_mode <= 1'b0;
		end else if (write_in && addr_in == `FSEC_OFS_CTRL) begin
			nvm_normal_mode <= wdata_in[`FSEC_NVM_MODE_BIT];
		end
	end

	// read data, one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_out <= 8'h00;
		end else if (read_in) begin
			if (addr_in == `FSEC_OFS_STATUS) begin
				rdata_out <= flash_protection_status;
			end else if (addr_in == `FSEC_OFS_CTRL) begin
				rdata_out <= {7'h00, nvm_normal_mode};
			end else begin
				rdata_out <= 8'h00;
			end
		end else begin
			rdata_out <= 8'h00;
		end
	end

	assign dec_secure = is_secure(next_status);

	// decoded indications, registered from the next register contents
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			// reset values equal the decode of the all-ones reset contents, so no false edge follows reset
			load_done_out <= 1'b0;
			backdoor_allowed_out <= 1'b0;
			bulk_erase_allowed_out <= 1'b1;
			factory_access_out <= 1'b1;
			program_flash_blocked_out <= 1'b0;
			secure_out <= 1'b1;
		end else begin
			load_done_out <= (load_state == flash_security_pkg::LOAD_DONE) || nvm_load_valid_in;
			backdoor_allowed_out <= (next_status[`FSEC_BACKDOOR_HI:`FSEC_BACKDOOR_LO] == `FSEC_CODE_10);
			bulk_erase_allowed_out <= !(dec_secure && !nvm_normal_mode
				&& next_status[`FSEC_ERASE_HI:`FSEC_ERASE_LO] == `FSEC_CODE_10);
			factory_access_out <= !dec_secure || factory_granted(next_status);
			program_flash_blocked_out <= dec_secure && !factory_granted(next_status);
			secure_out <= dec_secure;
		end
	end

	// backdoor unlock leaves the part unsecure on the next edge
	property p_unlock;
		@(posedge clk_in) disable iff (!resetn_in)
		(backdoor_unlock_in && load_state == flash_security_pkg::LOAD_DONE) |=> !secure_out;
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlock did not clear secure");

	// writes never change the status register
	property p_readonly;
		@(posedge clk_in) disable iff (!resetn_in)
		(write_in && !backdoor_unlock_in && load_state == flash_security_pkg::LOAD_DONE)
			|=> $stable(flash_protection_status);
	endproperty
	a_readonly: assert property (p_readonly) else $error("status changed on write");

	// load copies the nvm byte
	property p_load;
		@(posedge clk_in) disable iff (!resetn_in)
		(load_state == flash_security_pkg::LOAD_WAIT && nvm_load_valid_in && !backdoor_unlock_in)
			|=> flash_protection_status == $past(nvm_security_byte_in);
	endproperty
	a_load: assert property (p_load) else $error("nvm byte not loaded");

	// backdoor decode tracks register
	property p_backdoor;
		@(posedge clk_in) disable iff (!resetn_in)
		backdoor_allowed_out == (flash_protection_status[7:6] == 2'h2);
	endproperty
	a_backdoor: assert property (p_backdoor) else $error("backdoor decode wrong");

	// secure decode tracks register
	property p_secure;
		@(posedge clk_in) disable iff (!resetn_in)
		secure_out == (flash_protection_status[1:0] != 2'h2);
	endproperty
	a_secure: assert property (p_secure) else $error("secure decode wrong");

	// erase decode
	property p_erase;
		@(posedge clk_in) disable iff (!resetn_in)
		bulk_erase_allowed_out == !(flash_protection_status[1:0] != 2'h2
			&& flash_protection_status[5:4] == 2'h2 && !$past(nvm_normal_mode));
	endproperty
	a_erase: assert property (p_erase) else $error("bulk erase decode wrong");

	// factory decode
	property p_factory;
		@(posedge clk_in) disable iff (!resetn_in)
		factory_access_out == (flash_protection_status[1:0] == 2'h2
			|| flash_protection_status[3:2] == 2'h0 || flash_protection_status[3:2] == 2'h3);
	endproperty
	a_factory: assert property (p_factory) else $error("factory decode wrong");

	// blocked is exactly secure without factory access
	property p_blocked;
		@(posedge clk_in) disable iff (!resetn_in)
		program_flash_blocked_out == (secure_out && !factory_access_out);
	endproperty
	a_blocked: assert property (p_blocked) else $error("flash block decode wrong");

	// load status follows the load tracker
	property p_load_done;
		@(posedge clk_in) disable iff (!resetn_in)
		load_done_out == (load_state == flash_security_pkg::LOAD_DONE);
	endproperty
	a_load_done: assert property (p_load_done) else $error("load done flag wrong");

	// a second load after the first is ignored
	property p_load_once;
		@(posedge clk_in) disable iff (!resetn_in)
		(load_state == flash_security_pkg::LOAD_DONE && nvm_load_valid_in && !backdoor_unlock_in)
			|=> $stable(flash_protection_status);
	endproperty
	a_load_once: assert property (p_load_once) else $error("late load changed status");

	// unlock before the load is ignored
	property p_unlock_refused;
		@(posedge clk_in) disable iff (!resetn_in)
		(load_state == flash_security_pkg::LOAD_WAIT && backdoor_unlock_in && !nvm_load_valid_in)
			|=> $stable(flash_protection_status);
	endproperty
	a_unlock_refused: assert property (p_unlock_refused) else $error("early unlock changed status");

	// unlock rewrites only the state field
	property p_unlock_field;
		@(posedge clk_in) disable iff (!resetn_in)
		(backdoor_unlock_in && load_state == flash_security_pkg::LOAD_DONE)
			|=> flash_protection_status[1:0] == 2'h2
			&& flash_protection_status[7:2] == $past(flash_protection_status[7:2]);
	endproperty
	a_unlock_field: assert property (p_unlock_field) else $error("unlock touched other fields");

	// a status read returns the register one cycle later
	property p_rdata_status;
		@(posedge clk_in) disable iff (!resetn_in)
		(read_in && addr_in == `FSEC_OFS_STATUS)
			|=> rdata_out == $past(flash_protection_status);
	endproperty
	a_rdata_status: assert property (p_rdata_status) else $error("status read data wrong");

	// a control read returns the mode flag
	property p_rdata_ctrl;
		@(posedge clk_in) disable iff (!resetn_in)
		(read_in && addr_in == `FSEC_OFS_CTRL)
			|=> rdata_out == {7'h00, $past(nvm_normal_mode)};
	endproperty
	a_rdata_ctrl: assert property (p_rdata_ctrl) else $error("control read data wrong");

	// unmapped reads return zero
	property p_rdata_unmapped;
		@(posedge clk_in) disable iff (!resetn_in)
		(read_in && addr_in != `FSEC_OFS_STATUS && addr_in != `FSEC_OFS_CTRL)
			|=> rdata_out == 8'h00;
	endproperty
	a_rdata_unmapped: assert property (p_rdata_unmapped) else $error("unmapped read not zero");

	// read data fall back to zero without a read strobe
	property p_rdata_idle;
		@(posedge clk_in) disable iff (!resetn_in)
		!read_in |=> rdata_out == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("idle read data not zero");

	// unsecure always allows bulk erase
	property p_unsecure_erase;
		@(posedge clk_in) disable iff (!resetn_in)
		!secure_out |-> bulk_erase_allowed_out;
	endproperty
	a_unsecure_erase: assert property (p_unsecure_erase) else $error("erase blocked while unsecure");

	// normal nvm mode always allows bulk erase
	property p_mode_erase;
		@(posedge clk_in) disable iff (!resetn_in)
		$past(nvm_normal_mode) |-> bulk_erase_allowed_out;
	endproperty
	a_mode_erase: assert property (p_mode_erase) else $error("erase blocked in normal mode");

	// unsecure grants factory visibility and never blocks flash
	property p_unsecure_factory;
		@(posedge clk_in) disable iff (!resetn_in)
		!secure_out |-> factory_access_out && !program_flash_blocked_out;
	endproperty
	a_unsecure_factory: assert property (p_unsecure_factory) else $error("factory denied while unsecure");

	// flash blocking only happens while secure
	property p_blocked_secure;
		@(posedge clk_in) disable iff (!resetn_in)
		program_flash_blocked_out |-> secure_out;
	endproperty
	a_blocked_secure: assert property (p_blocked_secure) else $error("flash blocked while unsecure");

	// once loaded, an unsecure part stays unsecure until reset
	property p_unsecure_holds;
		@(posedge clk_in) disable iff (!resetn_in)
		(!secure_out && load_state == flash_security_pkg::LOAD_DONE)
			|=> !secure_out;
	endproperty
	a_unsecure_holds: assert property (p_unsecure_holds) else $error("part became secure again");

endmodule
`default_nettype wire

// ===== verif/flash_security_state_decoder_test.sv
// self-checking testbench for the flash security state decoder
`timescale 1ns/1ps
`default_nettype none
`include "flash_security_params.svh"
module flash_security_state_decoder_test;
	typedef struct {int due; bit is_rd; logic [7:0] val;} note_t;
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic nvm_load_valid_in = 1'b0;
	logic backdoor_unlock_in = 1'b0;
	logic write_in = 1'b0;
	logic read_in = 1'b0;
	logic [7:0] nvm_security_byte_in = 8'h00;
	logic [7:0] wdata_in = 8'h00;
	logic [`FSEC_ADDR_W-1:0] addr_in = '0;
	logic [7:0] rdata_out;
	logic load_done_out, backdoor_allowed_out, bulk_erase_allowed_out;
	logic factory_access_out, program_flash_blocked_out, secure_out;
	note_t notes[$];
	int cyc = 0;
	int num_errors = 0;
	int checks = 0;
	logic [7:0] b, m, u;

	flash_security_state_decoder dut_u (.clk_in(clk_in), .resetn_in(resetn_in),
		.nvm_security_byte_in(nvm_security_byte_in), .nvm_load_valid_in(nvm_load_valid_in),
		.backdoor_unlock_in(backdoor_unlock_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.write_in(write_in), .read_in(read_in), .rdata_out(rdata_out), .load_done_out(load_done_out),
		.backdoor_allowed_out(backdoor_allowed_out), .bulk_erase_allowed_out(bulk_erase_allowed_out),
		.factory_access_out(factory_access_out), .program_flash_blocked_out(program_flash_blocked_out),
		.secure_out(secure_out));

	// 10 MHz clock
	initial forever #50 clk_in = ~clk_in;

	// expected decoded outputs {0,0,loaded,backdoor,erase,factory,blocked,secure}
	function automatic logic [7:0] expect_dec(input logic [7:0] v, input logic [7:0] md);
		logic sec, fa;
		sec = v[1:0] != `FSEC_CODE_10;
		fa = v[3:2] == `FSEC_CODE_00 || v[3:2] == `FSEC_CODE_11;
		return {2'h0, 1'b1, v[7:6] == `FSEC_CODE_10, !(sec && !md[0] && v[5:4] == `FSEC_CODE_10), !sec || fa,
			sec && !fa, sec};
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (notes.size() != 0) num_errors++;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// note an expectation due d negative edges from now
	task automatic note(input bit is_rd, input logic [7:0] v, input int d);
		notes.push_back('{cyc + d, is_rd, v});
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		write_in <= 1'b1;
		@(posedge clk_in);
		write_in <= 1'b0;
	endtask

	// read data stand one cycle, then zero
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_in);
		addr_in <= a;
		read_in <= 1'b1;
		note(1'b1, e, 2);
		note(1'b1, 8'h00, 3);
		@(posedge clk_in);
		read_in <= 1'b0;
	endtask

	// load pulse or backdoor unlock pulse
	task automatic pulse(input bit unl, input logic [7:0] v, input logic [7:0] exp);
		@(posedge clk_in);
		nvm_security_byte_in <= v;
		nvm_load_valid_in <= !unl;
		backdoor_unlock_in <= unl;
		note(1'b0, exp, 2);
		@(posedge clk_in);
		nvm_load_valid_in <= 1'b0;
		backdoor_unlock_in <= 1'b0;
	endtask

	// monitor: compares every due note, oldest first, and cuts a hang short
	initial begin
		note_t n;
		forever begin
			@(negedge clk_in);
			cyc++;
			if (cyc > 5000) begin
				num_errors++;
				finish_test();
			end
			while (notes.size() > 0 && notes[0].due <= cyc) begin
				n = notes.pop_front();
				if (n.is_rd) chk(rdata_out, n.val);
				else chk({2'h0, load_done_out, backdoor_allowed_out, bulk_erase_allowed_out, factory_access_out, program_flash_blocked_out, secure_out}, n.val);
			end
		end
	end

	// main sequence: every field code, mode bit, write refusal, unlock, late load
	initial begin
		void'($urandom(32'hb100));
		for (int i = 0; i < 24; i++) begin
			b = i < 4 ? {4{i[1:0]}} : (i < 6 ? 8'h20 : 8'($urandom())); // i == 1 puts 01 in the backdoor field
			m = i < 5 ? 8'h00 : (i == 5 ? 8'h01 : 8'($urandom() & 1));
			u = {b[7:2], `FSEC_CODE_10};
			@(posedge clk_in);
			resetn_in <= 1'b0;
			repeat (12) @(posedge clk_in);
			resetn_in <= 1'b1;
			note(1'b0, expect_dec(`FSEC_RESET_STATUS, 8'h00) ^ 8'h20, 1);
			pulse(1'b1, b, expect_dec(`FSEC_RESET_STATUS, 8'h00) ^ 8'h20);
			wr(`FSEC_OFS_CTRL, m);
			pulse(1'b0, b, expect_dec(b, m));
			rd(`FSEC_OFS_STATUS, b);
			rd(`FSEC_OFS_CTRL, m);
			wr(`FSEC_OFS_STATUS, ~b);
			rd(`FSEC_OFS_STATUS, b);
			wr(4'hf, 8'h5a);
			rd(4'hf, 8'h00);
			pulse(1'b1, ~b, expect_dec(u, m));
			rd(`FSEC_OFS_STATUS, u);
			pulse(1'b0, ~b, expect_dec(u, m));
			repeat (4) @(posedge clk_in);
			$display("test %0d done, byte %h mode %h", i, b, m);
		end
		finish_test();
	end
endmodule
`default_nettype wire
